// ==== hdl/pbseq_pkg.sv ====
// Constants shared by the pushbutton power sequencer.
// Assumes one 125 MHz system clock and inputs synchronous to it.

package pbseq_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int unsigned CLK_HZ = 125000000;
  localparam int unsigned DEBOUNCE_MS = 24;
  localparam int unsigned DEBOUNCE_CYC = DEBOUNCE_MS * (CLK_HZ / 1000);
  localparam int unsigned INIT_US = 10;
  localparam int unsigned INIT_CYC = INIT_US * (CLK_HZ / 1000000);
  // Reset duration: 1 uA into the cap up to 1.2 V; default models 10 nF (12 ms).
  localparam int unsigned RST_CAP_PF = 10000;
  localparam int unsigned RST_UA = 1;
  localparam int unsigned RST_MV = 1200;
  localparam int unsigned RST_NS = (RST_CAP_PF / 1000) * RST_MV / RST_UA * 1000;
  localparam int unsigned RST_CYC = RST_NS / 8;
  // Shared converter oscillator 1.27 MHz, half period in system cycles.
  localparam int unsigned OSC_KHZ = 1270;
  localparam int unsigned OSC_HALF_CYC = (CLK_HZ / 1000) / (2 * OSC_KHZ);
  localparam int unsigned CNT_W = 32;

  typedef enum {PBSEQ_STANDBY, PBSEQ_INIT, PBSEQ_SEQ, PBSEQ_RUN, PBSEQ_FAULT} pbseq_state_e;

endpackage : pbseq_pkg

// ==== hdl/pbseq_counter.sv ====
// Saturating up-counter that reports when a programmed terminal count is held.
// Assumes the caller clears it while its qualifying condition is false.
`timescale 1ns/1ps
`default_nettype none

module pbseq_counter #(
  parameter int unsigned WIDTH = 32
) (
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic run_in,
  input wire logic [WIDTH-1:0] limit_in,
  output logic done_out
);

  logic [WIDTH-1:0] count_reg;
  wire logic at_limit = (count_reg >= limit_in);

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      count_reg <= '0;
    end else if (!run_in) begin
      count_reg <= '0;
    end else if (!at_limit) begin
      count_reg <= count_reg + {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end

  // Done only while still running, so a drop of the condition ends it at once.
  assign done_out = run_in && at_limit;

endmodule // pbseq_counter

`default_nettype wire

// ==== hdl/pbseq_osc.sv ====
// Divider that makes the shared converter switching clock from the system clock.
// Assumes the converters sample only the edges of the clock it drives.
`timescale 1ns/1ps
`default_nettype none

module pbseq_osc #(
  parameter int unsigned HALF = 49
) (
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  output logic osc_out
);

  logic [15:0] div_reg;
  logic osc_reg;
  wire logic wrap = (div_reg == 16'(HALF - 1));

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      div_reg <= 16'h0000;
      osc_reg <= 1'b0;
    end else begin
      div_reg <= wrap ? 16'h0000 : div_reg + 16'h0001;
      osc_reg <= wrap ? ~osc_reg : osc_reg;
    end
  end

  assign osc_out = osc_reg;

endmodule // pbseq_osc

`default_nettype wire

// ==== hdl/pbseq_top.sv ====
// Control logic of the pushbutton power sequencer: debounce, sequencing, reset timer.
// Assumes all inputs synchronous to sys_clk_in; power-good inputs come from converters.
`timescale 1ns/1ps
`default_nettype none

module pbseq_top #(
  parameter int unsigned DEBOUNCE_CYC = pbseq_pkg::DEBOUNCE_CYC,
  parameter int unsigned RST_CYC = pbseq_pkg::RST_CYC,
  parameter int unsigned INIT_CYC = pbseq_pkg::INIT_CYC
) (
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic power_hold_in,
  input wire logic pushbutton_in,
  input wire logic buck_one_enable_in,
  input wire logic buck_two_enable_in,
  input wire logic buckboost_enable_in,
  input wire logic buck_one_pgood_in,
  input wire logic buck_two_pgood_in,
  input wire logic buckboost_pgood_in,
  input wire logic overtemp_in,
  input wire logic undervolt_in,
  input wire logic pulse_skip_in,
  output logic button_status_out,
  output logic button_status_oe_n_out,
  output logic buck_one_on_out,
  output logic buck_two_on_out,
  output logic buckboost_on_out,
  output logic hot_plug_output_out,
  output logic discharge_out,
  output logic always_alive_on_out,
  output logic reset_n_out,
  output logic pulse_skip_out,
  output logic osc_out,
  output logic reset_timing_cap_out
);

  // ****************************************************************
  // Debounce
  // ****************************************************************
  logic pressed_reg;
  logic press_done;
  logic release_done;
  logic osc_raw;

  // Two counters: one qualifies a steady low, the other a steady high.
  pbseq_counter #(.WIDTH(pbseq_pkg::CNT_W)) u_press (
    .sys_clk_in(sys_clk_in),
    .rst_n_in(rst_n_in),
    .run_in(!pushbutton_in && !pressed_reg),
    .limit_in(pbseq_pkg::CNT_W'(DEBOUNCE_CYC)),
    .done_out(press_done)
  );

  pbseq_counter #(.WIDTH(pbseq_pkg::CNT_W)) u_release (
    .sys_clk_in(sys_clk_in),
    .rst_n_in(rst_n_in),
    .run_in(pushbutton_in && pressed_reg),
    .limit_in(pbseq_pkg::CNT_W'(DEBOUNCE_CYC)),
    .done_out(release_done)
  );

  pbseq_osc #(.HALF(pbseq_pkg::OSC_HALF_CYC)) u_osc (
    .sys_clk_in(sys_clk_in),
    .rst_n_in(rst_n_in),
    .osc_out(osc_raw)
  );

  wire logic pressed_next = press_done ? 1'b1 : (release_done ? 1'b0 : pressed_reg);

  // ****************************************************************
  // Enable and fault decode
  // ****************************************************************
  // An undriven power-hold reads low by the pull-down, so a plain level test suffices.
  wire logic enable_req = power_hold_in || pressed_reg;
  wire logic hard_fault = overtemp_in || undervolt_in;

  pbseq_pkg::pbseq_state_e state_reg;
  pbseq_pkg::pbseq_state_e state_next;
  logic init_done;
  logic timer_done;
  logic b1_reg, b2_reg, bb_reg, hso_reg;
  logic rst_n_reg, dis_reg, ps_reg, osc_reg;
  // Status enable and always-alive flag are registered so every pin but the constant button_status_out leaves a flop.
  logic oe_n_reg, alive_reg;
  logic timer_run_reg;

  pbseq_counter #(.WIDTH(pbseq_pkg::CNT_W)) u_init (
    .sys_clk_in(sys_clk_in),
    .rst_n_in(rst_n_in),
    .run_in(state_reg == pbseq_pkg::PBSEQ_INIT),
    .limit_in(pbseq_pkg::CNT_W'(INIT_CYC)),
    .done_out(init_done)
  );

  // Sequence stage: a disabled channel counts as already regulated so it is skipped.
  wire logic b1_ok = !buck_one_enable_in || buck_one_pgood_in;
  wire logic b2_ok = !buck_two_enable_in || buck_two_pgood_in;
  wire logic bb_ok = !buckboost_enable_in || buckboost_pgood_in;
  wire logic all_ok = b1_ok && b2_ok && bb_ok;
  // Custom order: no enable high at the end of init means hand-driven enables.
  wire logic none_en = !buck_one_enable_in && !buck_two_enable_in && !buckboost_enable_in;

  wire logic b1_next = buck_one_enable_in;
  wire logic b2_next = buck_two_enable_in && (state_reg == pbseq_pkg::PBSEQ_RUN || b1_ok);
  wire logic bb_next = buckboost_enable_in
                       && (state_reg == pbseq_pkg::PBSEQ_RUN || (b1_ok && b2_ok));
  wire logic on_state = (state_reg == pbseq_pkg::PBSEQ_SEQ) || (state_reg == pbseq_pkg::PBSEQ_RUN);

  // Reset timer charges only while every enabled rail is good and no hard fault is present.
  wire logic timer_run_next = on_state && all_ok && !hard_fault;

  pbseq_counter #(.WIDTH(pbseq_pkg::CNT_W)) u_rst (
    .sys_clk_in(sys_clk_in),
    .rst_n_in(rst_n_in),
    .run_in(timer_run_reg),
    .limit_in(pbseq_pkg::CNT_W'(RST_CYC)),
    .done_out(timer_done)
  );

  // ****************************************************************
  // State machine
  // ****************************************************************
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      pbseq_pkg::PBSEQ_STANDBY: begin
        if (enable_req && !hard_fault) begin
          state_next = pbseq_pkg::PBSEQ_INIT;
        end
      end
      pbseq_pkg::PBSEQ_INIT: begin
        if (init_done) begin
          state_next = none_en ? pbseq_pkg::PBSEQ_RUN : pbseq_pkg::PBSEQ_SEQ;
        end
      end
      pbseq_pkg::PBSEQ_SEQ: begin
        if (all_ok) begin
          state_next = pbseq_pkg::PBSEQ_RUN;
        end
      end
      pbseq_pkg::PBSEQ_RUN: begin
        state_next = pbseq_pkg::PBSEQ_RUN;
      end
      pbseq_pkg::PBSEQ_FAULT: begin
        if (!hard_fault) begin
          state_next = pbseq_pkg::PBSEQ_SEQ;
        end
      end
      default: begin
        state_next = pbseq_pkg::PBSEQ_STANDBY;
      end
    endcase
    // Losing the enable ends any state; faults override except in standby.
    if (!enable_req) begin
      state_next = pbseq_pkg::PBSEQ_STANDBY;
    end else if (hard_fault && state_reg != pbseq_pkg::PBSEQ_STANDBY) begin
      state_next = pbseq_pkg::PBSEQ_FAULT;
    end
  end

  wire logic go_on = (state_next == pbseq_pkg::PBSEQ_SEQ) || (state_next == pbseq_pkg::PBSEQ_RUN);

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_reg <= pbseq_pkg::PBSEQ_STANDBY;
      pressed_reg <= 1'b0;
      timer_run_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      pressed_reg <= pressed_next;
      timer_run_reg <= timer_run_next;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  // Converters hold through regulation loss; only faults or disable turn them off.
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      b1_reg <= 1'b0;
      b2_reg <= 1'b0;
      bb_reg <= 1'b0;
      hso_reg <= 1'b0;
      rst_n_reg <= 1'b0;
      dis_reg <= 1'b1;
      ps_reg <= 1'b0;
      osc_reg <= 1'b0;
      oe_n_reg <= 1'b1;
      alive_reg <= 1'b1;
    end else begin
      b1_reg <= go_on && b1_next;
      b2_reg <= go_on && buck_two_enable_in && (b2_next || b2_reg);
      bb_reg <= go_on && buckboost_enable_in && (bb_next || bb_reg);
      hso_reg <= go_on && buckboost_enable_in && buckboost_pgood_in;
      rst_n_reg <= on_state && go_on && timer_done;
      dis_reg <= (state_next == pbseq_pkg::PBSEQ_STANDBY);
      ps_reg <= pulse_skip_in;
      osc_reg <= osc_raw;
      oe_n_reg <= !pressed_next;
      alive_reg <= (state_next != pbseq_pkg::PBSEQ_FAULT);
    end
  end

  assign buck_one_on_out = b1_reg;
  assign buck_two_on_out = b2_reg;
  assign buckboost_on_out = bb_reg;
  assign hot_plug_output_out = hso_reg;
  assign reset_n_out = rst_n_reg;
  assign discharge_out = dis_reg;
  assign pulse_skip_out = ps_reg;
  assign osc_out = osc_reg;
  // Open drain: output level is always low; the enable pulls only while pressed.
  assign button_status_out = 1'b0;
  assign button_status_oe_n_out = oe_n_reg;
  assign always_alive_on_out = alive_reg;
  // The cap pin is held low whenever the timer is cleared.
  assign reset_timing_cap_out = timer_run_reg;

  // ****************************************************************
  // Checks
  // ****************************************************************
  a_reset_when_off: assert property (
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    (state_reg == pbseq_pkg::PBSEQ_STANDBY) |-> !reset_n_out)
    else $error("Reset released while disabled");

  a_fault_rails_off: assert property (
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    hard_fault |=> !buck_one_on_out && !buck_two_on_out && !buckboost_on_out && !reset_n_out)
    else $error("Rails on during hard fault");

  a_pgood_loss_rst: assert property (
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    (on_state && !all_ok) |=> ##1 !reset_n_out)
    else $error("Reset not asserted on regulation loss");

  a_bb_after_b12: assert property (
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    ($rose(buckboost_on_out) && $past(state_reg) == pbseq_pkg::PBSEQ_SEQ)
      |-> $past(b1_ok) && $past(b2_ok))
    else $error("Buck-boost started before earlier rails good");

  a_b2_after_b1: assert property (
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    ($rose(buck_two_on_out) && $past(state_reg) == pbseq_pkg::PBSEQ_SEQ) |-> $past(b1_ok))
    else $error("Buck two started before buck one good");

  a_hso_needs_pg: assert property (
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    hot_plug_output_out |-> $past(buckboost_pgood_in))
    else $error("Hot-plug output without buck-boost power good");

  a_status_press: assert property (
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    press_done |=> !button_status_oe_n_out
      ##1 (state_reg != pbseq_pkg::PBSEQ_STANDBY || hard_fault))
    else $error("Press not reported or not enabling");

  a_release_off: assert property (
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    (!power_hold_in && !pressed_reg) |=> discharge_out && !buck_one_on_out)
    else $error("Device not disabled on release");

  a_rst_timer: assert property (
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    $rose(reset_n_out) |-> $past(timer_done))
    else $error("Reset released before timer expiry");

  a_skip_chan: assert property (
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    ($rose(buckboost_on_out) && $past(state_reg) == pbseq_pkg::PBSEQ_SEQ
      && !$past(buck_two_enable_in)) |-> $past(b1_ok))
    else $error("Buck-boost started early with buck two skipped");

  a_custom_direct: assert property (
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    (state_reg == pbseq_pkg::PBSEQ_RUN && buck_one_enable_in && enable_req && !hard_fault)
      |=> buck_one_on_out)
    else $error("Raised enable did not start its converter");

  a_hold_on_loss: assert property (
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    (state_reg == pbseq_pkg::PBSEQ_RUN && buck_two_on_out && buck_two_enable_in
      && enable_req && !hard_fault) |=> buck_two_on_out)
    else $error("Converter dropped while held");

  a_mode_copy: assert property (
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    pulse_skip_out == $past(pulse_skip_in))
    else $error("Mode output does not follow mode input");

  a_standby_off: assert property (
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    (state_reg == pbseq_pkg::PBSEQ_STANDBY && $past(state_reg) == pbseq_pkg::PBSEQ_STANDBY)
      |-> discharge_out && !hot_plug_output_out && always_alive_on_out)
    else $error("Standby outputs wrong");

  a_release_status: assert property (
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    release_done |=> button_status_oe_n_out)
    else $error("Status still pulled after debounced release");

  a_hard_alive: assert property (
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    (hard_fault && enable_req && state_reg != pbseq_pkg::PBSEQ_STANDBY)
      |=> !always_alive_on_out)
    else $error("Always-alive rails on during hard fault");

  // ****************************************************************
  // Cover points
  // ****************************************************************
  c_press: cover property (@(posedge sys_clk_in) disable iff (!rst_n_in) press_done);
  c_run: cover property (@(posedge sys_clk_in) disable iff (!rst_n_in) $rose(reset_n_out));
  c_fault: cover property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    state_reg == pbseq_pkg::PBSEQ_FAULT ##1 state_reg == pbseq_pkg::PBSEQ_SEQ);
  c_custom: cover property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    state_reg == pbseq_pkg::PBSEQ_INIT ##1 state_reg == pbseq_pkg::PBSEQ_RUN);
  c_skip: cover property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    $rose(buckboost_on_out) && !buck_two_enable_in);

endmodule // pbseq_top

`default_nettype wire

// ==== verification/pbseq_conv_model.sv ====
// Behavioural model of the three converters behind the sequencer.
// Assumes enables come from the sequencer and loss is commanded by the bench.
`timescale 1ns/1ps
`default_nettype none

module pbseq_conv_model #(
  parameter int DLY = 4
) (
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic [2:0] on_in,
  input wire logic [2:0] loss_in,
  output logic [2:0] pgood_out
);
  // Power good needs a real ramp time, so a sequencer that skips waiting shows up.
  for (genvar g = 0; g < 3; g++) begin : g_ch
    logic [7:0] cnt_reg;
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) cnt_reg <= 8'h00;
      else if (!on_in[g]) cnt_reg <= 8'h00;
      else if (cnt_reg < 8'(DLY)) cnt_reg <= cnt_reg + 8'h01;
    end
    assign pgood_out[g] = on_in[g] && !loss_in[g] && (cnt_reg == 8'(DLY));
  end
endmodule // pbseq_conv_model
`default_nettype wire

// ==== verification/tb_pushbutton_power_sequencer.sv ====
// Self-checking bench of the pushbutton power sequencer.
// Assumes a converter model answers the rail enables with power good.
`timescale 1ns/1ps
`default_nettype none

module tb_pushbutton_power_sequencer;
  localparam int DEB = 20;
  localparam int RST = 30;
  localparam int INI = 5;
  logic sys_clk_in, rst_n_in, power_hold_in, pushbutton_in, pulse_skip_in;
  logic overtemp_in, undervolt_in, order_chk;
  logic [2:0] ena, loss;
  wire [2:0] pg;
  wire logic on0, on1, on2, bs, oe_n, hot_plug_output, dis, alive, reset_n, ps_out, osc, cap;
  wire [2:0] on = {on2, on1, on0};
  int fail_count, n_compared, waited, i;
  // Rows: enables, then expected rails and hot-plug state.
  logic [6:0] rows [8] = '{7'h00, 7'h12, 7'h24, 7'h36, 7'h49, 7'h5b, 7'h6d, 7'h7f};

  pbseq_top #(.DEBOUNCE_CYC(DEB), .RST_CYC(RST), .INIT_CYC(INI)) dut_u (
    .sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .power_hold_in(power_hold_in),
    .pushbutton_in(pushbutton_in), .buck_one_enable_in(ena[0]),
    .buck_two_enable_in(ena[1]), .buckboost_enable_in(ena[2]),
    .buck_one_pgood_in(pg[0]), .buck_two_pgood_in(pg[1]), .buckboost_pgood_in(pg[2]),
    .overtemp_in(overtemp_in), .undervolt_in(undervolt_in), .pulse_skip_in(pulse_skip_in),
    .button_status_out(bs), .button_status_oe_n_out(oe_n), .buck_one_on_out(on0),
    .buck_two_on_out(on1), .buckboost_on_out(on2), .hot_plug_output_out(hot_plug_output),
    .discharge_out(dis), .always_alive_on_out(alive), .reset_n_out(reset_n),
    .pulse_skip_out(ps_out), .osc_out(osc), .reset_timing_cap_out(cap)
  );
  pbseq_conv_model #(.DLY(4)) model_u (
    .sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .on_in(on), .loss_in(loss), .pgood_out(pg)
  );

  // ****************************************************************
  // Clock, watchdog and helpers
  // ****************************************************************
  initial begin
    sys_clk_in = 1'b0;
    forever #4 sys_clk_in = ~sys_clk_in;
  end
  initial begin
    repeat (20000) @(posedge sys_clk_in);
    fail_count++;
    tally_and_finish();
  end
  // A rail that rises before the rail it follows is regulated breaks the order.
  always @(posedge sys_clk_in) begin
    if (order_chk && rst_n_in && $rose(on1) && ena[0] && !pg[0]) begin
      $display("[ERR] %0t buck two early", $time);
      fail_count++;
    end
    if (order_chk && rst_n_in && $rose(on2) && ((ena[1] && !pg[1]) ||
        (ena[0] && !ena[1] && !pg[0]))) begin
      $display("[ERR] %0t buck-boost early", $time);
      fail_count++;
    end
    if (rst_n_in && $rose(hot_plug_output) && !pg[2]) begin
      $display("[ERR] %0t hot-plug early", $time);
      fail_count++;
    end
  end
  task automatic step(input int n);
    repeat (n) @(posedge sys_clk_in);
    #1;
  endtask
  task automatic chk(input logic got, input logic exp, input string msg);
    n_compared++;
    if (got !== exp) begin
      $display("[ERR] %0t %s", $time, msg);
      fail_count++;
    end
  endtask
  task automatic wait_sig(input int sel, input logic val, input int lim);
    logic cur;
    waited = 0;
    while (waited < lim) begin
      case (sel)
        0: cur = hot_plug_output;
        1: cur = reset_n;
        2: cur = oe_n;
        3: cur = on0;
        default: cur = osc;
      endcase
      if (cur === val) break;
      step(1);
      waited++;
    end
  endtask
  task automatic tally_and_finish();
    if (fail_count == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // ****************************************************************
  // Tests
  // ****************************************************************
  initial begin
    {fail_count, n_compared, overtemp_in, undervolt_in, pulse_skip_in} = '0;
    {rst_n_in, power_hold_in, loss, order_chk} = '0;
    pushbutton_in = 1'b1;
    ena = 3'b111;
    step(6);
    chk(reset_n, 1'b0, "reset out high in reset");
    chk(oe_n, 1'b1, "status pulled in reset");
    rst_n_in = 1'b1;
    order_chk = 1'b1;
    step(3);
    chk(alive, 1'b1, "always-alive off in standby");
    chk(on === 3'b000 && dis === 1'b1, 1'b1, "rails on in standby");
    pushbutton_in = 1'b0;
    step(DEB / 2);
    pushbutton_in = 1'b1;
    step(DEB + 5);
    chk(oe_n === 1'b1 && on === 3'b000, 1'b1, "short press accepted");
    pushbutton_in = 1'b0;
    step(DEB - 2);
    chk(oe_n, 1'b1, "press qualified early");
    wait_sig(2, 1'b0, 10);
    chk(oe_n === 1'b0 && bs === 1'b0, 1'b1, "press not reported");
    wait_sig(0, 1'b1, 60);
    chk(on === 3'b111 && hot_plug_output === 1'b1, 1'b1, "sequence incomplete");
    step(RST / 2);
    chk(reset_n === 1'b0 && cap === 1'b1, 1'b1, "reset released early");
    wait_sig(1, 1'b1, RST + 10);
    chk(reset_n, 1'b1, "reset never released");
    pushbutton_in = 1'b1;
    wait_sig(3, 1'b0, DEB + 10);
    chk(dis === 1'b1 && hot_plug_output === 1'b0 && reset_n === 1'b0, 1'b1, "not disabled");
    pushbutton_in = 1'b0;
    wait_sig(1, 1'b1, DEB + RST + 80);
    power_hold_in = 1'b1;
    step(2);
    pushbutton_in = 1'b1;
    wait_sig(2, 1'b1, DEB + 10);
    chk(oe_n === 1'b1 && on === 3'b111, 1'b1, "release handling");
    pushbutton_in = 1'b0;
    wait_sig(2, 1'b0, DEB + 10);
    chk(oe_n, 1'b0, "second press lost");
    pushbutton_in = 1'b1;
    wait_sig(2, 1'b1, DEB + 10);
    power_hold_in = 1'b0;
    wait_sig(3, 1'b0, 5);
    chk(on === 3'b000 && reset_n === 1'b0, 1'b1, "power-down failed");
    for (i = 0; i < 8; i++) begin
      ena = rows[i][6:4];
      step(1);
      power_hold_in = 1'b1;
      step(60);
      chk(on === rows[i][3:1] && hot_plug_output === rows[i][0], 1'b1, "row rails");
      power_hold_in = 1'b0;
      step(3);
      chk(on === 3'b000, 1'b1, "row rails left on");
    end
    ena = 3'b111;
    power_hold_in = 1'b1;
    wait_sig(1, 1'b1, 120);
    loss = 3'b010;
    step(3);
    chk(reset_n === 1'b0 && cap === 1'b0, 1'b1, "regulation loss ignored");
    chk(on === 3'b111, 1'b1, "rails dropped on loss");
    loss = 3'b000;
    step(RST / 2);
    chk(reset_n, 1'b0, "timer not restarted");
    wait_sig(1, 1'b1, RST + 10);
    chk(reset_n, 1'b1, "no recovery");
    for (i = 0; i < 2; i++) begin
      {undervolt_in, overtemp_in} = (i == 0) ? 2'b01 : 2'b10;
      step(3);
      chk(on === 3'b000 && alive === 1'b0, 1'b1, "fault rails on");
      chk(reset_n === 1'b0 && cap === 1'b0, 1'b1, "fault reset");
      {undervolt_in, overtemp_in} = 2'b00;
      wait_sig(1, 1'b1, RST + 80);
      chk(reset_n === 1'b1 && on === 3'b111, 1'b1, "no rerun after fault");
    end
    power_hold_in = 1'b0;
    ena = 3'b000;
    step(3);
    power_hold_in = 1'b1;
    step(INI + 5);
    order_chk = 1'b0;
    ena = 3'b111;
    wait_sig(3, 1'b1, 10);
    chk(on === 3'b111, 1'b1, "joint start split");
    pulse_skip_in = 1'b1;
    step(2);
    chk(ps_out, 1'b1, "mode not set");
    pulse_skip_in = 1'b0;
    step(2);
    chk(ps_out, 1'b0, "mode not cleared");
    wait_sig(4, 1'b0, 200);
    wait_sig(4, 1'b1, 200);
    wait_sig(4, 1'b0, 200);
    chk(waited == int'(pbseq_pkg::OSC_HALF_CYC), 1'b1, "oscillator period");
    tally_and_finish();
  end
endmodule // tb_pushbutton_power_sequencer
`default_nettype wire
